// ===== design/sync_processor.sv
// sync signal processor: polarity, detection, separation, pseudo syncs, counters
`timescale 1ns/10ps
`default_nettype none
`include "sync_processor_cfg.svh"

module sync_processor
  import sync_processor_pkg::*;
#(
  parameter int unsigned FRAME_PERIOD_CYCLES = `BUS_TO_CLK(`FRAME_PERIOD_MAX),
  parameter int unsigned PSEUDO_FRAME_CYCLES = `BUS_TO_CLK(`PSEUDO_FRAME)
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_sync_in,
  input  wire logic        frame_sync_in,
  input  wire logic        cpu_irq_mask,
  input  wire logic        vector_fetch,
  output logic             frame_irq,
  output logic             line_sync_out,
  output logic             frame_sync_out
);
  localparam int unsigned BUS_DIV = `BUS_NS / `CLK_NS;
  localparam int unsigned CW = 20;
  localparam logic [CW-1:0] FRAME_LOW   = CW'(`BUS_TO_CLK(`FRAME_LOW_LIMIT));
  localparam logic [CW-1:0] LONG_P      = CW'(`BUS_TO_CLK(`LONG_PULSE));
  localparam logic [CW-1:0] FW_MAX      = CW'(`BUS_TO_CLK(`FRAME_WIDTH_MAX));
  localparam logic [CW-1:0] FP_MAX      = CW'(FRAME_PERIOD_CYCLES);
  localparam logic [CW-1:0] LW_MAX      = CW'(`BUS_TO_CLK(`LINE_WIDTH_MAX));
  localparam logic [CW-1:0] LP_MIN      = CW'(`BUS_TO_CLK(`LINE_PERIOD_MIN));
  localparam logic [CW-1:0] LP_MAX      = CW'(`BUS_TO_CLK(`LINE_PERIOD_MAX));
  localparam logic [CW-1:0] PF_PER      = CW'(PSEUDO_FRAME_CYCLES);
  localparam logic [CW-1:0] PL_SLOW     = CW'(`BUS_TO_CLK(`PSEUDO_LINE_SLOW));
  localparam logic [CW-1:0] PL_FAST     = CW'(`BUS_TO_CLK(`PSEUDO_LINE_FAST));
  localparam logic [CW-1:0] WIDEN       = CW'(`WIDEN_CYCLES);
  localparam logic [CW-1:0] PSEUDO_LOW  = CW'(BUS_DIV);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1, rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // glitch filter: level accepted after one bus period stable
  // ----------------------------------------------------------------
  sync_pair_t raw, filt;
  logic [3:0] hf_cnt, vf_cnt;
  assign raw.line  = line_sync_in;
  assign raw.frame = frame_sync_in;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt   <= '{line: 1'b1, frame: 1'b1};
      hf_cnt <= 4'h0;
      vf_cnt <= 4'h0;
    end else begin
      if (raw.line == filt.line) hf_cnt <= 4'h0;
      else if (hf_cnt == 4'(BUS_DIV - 1)) begin
        filt.line <= raw.line;
        hf_cnt    <= 4'h0;
      end else hf_cnt <= hf_cnt + 4'h1;
      if (raw.frame == filt.frame) vf_cnt <= 4'h0;
      else if (vf_cnt == 4'(BUS_DIV - 1)) begin
        filt.frame <= raw.frame;
        vf_cnt     <= 4'h0;
      end else vf_cnt <= vf_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // polarity correction
  // ----------------------------------------------------------------
  control_status_t cs;
  logic frame_polarity_flag, line_polarity_flag, frame_detect_flag, line_detect_flag;
  logic output_source_select, insertion_inhibit, pseudo_rate_select, input_source_select;
  logic            h_prev, v_prev, h_edge, v_edge;
  logic [CW-1:0]   h_run, v_run;
  logic [3:0]      low_long_cnt, high_long_cnt;
  assign cs = {frame_polarity_flag, line_polarity_flag, frame_detect_flag, line_detect_flag,
               output_source_select, insertion_inhibit, pseudo_rate_select, input_source_select};
  assign h_edge = filt.line != h_prev;
  assign v_edge = filt.frame != v_prev;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      h_prev <= 1'b1;
      v_prev <= 1'b1;
      h_run  <= '0;
      v_run  <= '0;
    end else begin
      h_prev <= filt.line;
      v_prev <= filt.frame;
      h_run  <= h_edge ? '0 : (&h_run ? h_run : h_run + 1'b1);
      v_run  <= v_edge ? '0 : (&v_run ? v_run : v_run + 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_polarity_flag <= 1'b0;
      line_polarity_flag  <= 1'b0;
      low_long_cnt           <= 4'h0;
      high_long_cnt          <= 4'h0;
    end else begin
      if (!filt.frame && v_run > FRAME_LOW) frame_polarity_flag <= 1'b1;
      else if (v_edge && !v_prev && v_run <= FRAME_LOW) frame_polarity_flag <= 1'b0;
      if (h_edge && h_run > LONG_P) begin
        if (!h_prev) begin
          high_long_cnt <= 4'h0;
          low_long_cnt  <= (low_long_cnt == 4'(`POL_COUNT - 1)) ? 4'h0 : low_long_cnt + 4'h1;
          if (low_long_cnt == 4'(`POL_COUNT - 1)) line_polarity_flag <= 1'b1;
        end else begin
          low_long_cnt  <= 4'h0;
          high_long_cnt <= (high_long_cnt == 4'(`POL_COUNT - 1)) ? 4'h0 : high_long_cnt + 4'h1;
          if (high_long_cnt == 4'(`POL_COUNT - 1)) line_polarity_flag <= 1'b0;
        end
      end
    end
  end

  logic h_neg, v_neg, hp_neg;
  assign h_neg  = filt.line ^ cs.line_polarity_flag;
  assign v_neg  = filt.frame ^ cs.frame_polarity_flag;
  assign hp_neg = h_prev ^ cs.line_polarity_flag;

  // ----------------------------------------------------------------
  // composite separation
  // ----------------------------------------------------------------
  sep_state_t    sep;
  logic [11:0]   hpulse_cnt, hold_lines;
  logic [CW-1:0] lo_dur, hi_dur;
  logic          sep_v, sep_h, vert_mark;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo_dur <= '0;
      hi_dur <= '0;
    end else begin
      lo_dur <= h_neg ? '0 : (&lo_dur ? lo_dur : lo_dur + 1'b1);
      hi_dur <= !h_neg ? '0 : (&hi_dur ? hi_dur : hi_dur + 1'b1);
    end
  end
  assign vert_mark = !h_neg && lo_dur == LONG_P;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hpulse_cnt <= 12'h000;
      hold_lines <= 12'h000;
    end else if (vert_mark) begin
      hold_lines <= hpulse_cnt;
      hpulse_cnt <= 12'h000;
    end else if (h_neg && !hp_neg && lo_dur <= LONG_P) begin
      hpulse_cnt <= hpulse_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sep   <= SEP_PASS;
      sep_v <= 1'b1;
    end else begin
      unique case (sep)
        SEP_PASS: if (hpulse_cnt == hold_lines && hold_lines != 12'h000) sep <= SEP_ARMED;
        SEP_ARMED: if (!h_neg && hp_neg) begin
          sep   <= SEP_VERT;
          sep_v <= 1'b0;
        end
        SEP_VERT: if (hi_dur > LONG_P) begin
          sep   <= SEP_PASS;
          sep_v <= 1'b1;
        end
      endcase
    end
  end

  logic [CW-1:0] line_per, emu_cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_per <= LP_MAX;
      emu_cnt  <= '0;
    end else begin
      if (h_neg && !hp_neg && h_run < LP_MAX && sep == SEP_PASS) line_per <= h_run + 1'b1;
      emu_cnt <= (emu_cnt >= line_per - 1'b1) ? '0 : emu_cnt + 1'b1;
    end
  end
  assign sep_h = (sep == SEP_PASS) ? h_neg : (emu_cnt >= LW_MAX / 2);

  // ----------------------------------------------------------------
  // reshaper: composite frame pulse widened
  // ----------------------------------------------------------------
  logic [CW-1:0] widen_cnt;
  logic          v_shaped;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) widen_cnt <= '0;
    else if (!sep_v) widen_cnt <= WIDEN;
    else if (widen_cnt != '0) widen_cnt <= widen_cnt - 1'b1;
  end
  assign v_shaped = cs.input_source_select ? v_neg
                  : (sep_v && widen_cnt == '0);

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  logic [CW-1:0] v_per_cnt, h_per_cnt;
  logic          v_src, h_src, vs_prev;
  assign v_src = cs.input_source_select ? v_neg : sep_v;
  assign h_src = h_neg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vs_prev              <= 1'b1;
      v_per_cnt            <= '0;
      h_per_cnt            <= '0;
      frame_detect_flag    <= 1'b0;
      line_detect_flag     <= 1'b0;
    end else begin
      vs_prev <= v_src;
      if (vs_prev && !v_src) begin
        frame_detect_flag <= v_per_cnt < FP_MAX;
        v_per_cnt         <= '0;
      end else begin
        v_per_cnt <= &v_per_cnt ? v_per_cnt : v_per_cnt + 1'b1;
        if (v_per_cnt >= FP_MAX) frame_detect_flag <= 1'b0;
        if (!v_src && v_run >= FW_MAX && cs.input_source_select)
          frame_detect_flag <= 1'b0;
      end
      if (hp_neg && !h_src) begin
        line_detect_flag <= h_per_cnt > LP_MIN && h_per_cnt < LP_MAX;
        h_per_cnt        <= '0;
      end else begin
        h_per_cnt <= &h_per_cnt ? h_per_cnt : h_per_cnt + 1'b1;
        if (h_per_cnt >= LP_MAX) line_detect_flag <= 1'b0;
        if (!h_src && lo_dur >= LW_MAX && cs.input_source_select)
          line_detect_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pseudo sync generator
  // ----------------------------------------------------------------
  logic [CW-1:0] pf_cnt, pl_cnt, pl_per;
  logic          pseudo_run;
  assign pseudo_run = !(cs.frame_detect_flag && cs.line_detect_flag);
  assign pl_per = cs.pseudo_rate_select ? PL_FAST : PL_SLOW;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pf_cnt <= '0;
      pl_cnt <= '0;
    end else if (pseudo_run || !cs.output_source_select) begin
      pf_cnt <= (pf_cnt >= PF_PER - 1'b1) ? '0 : pf_cnt + 1'b1;
      pl_cnt <= (pl_cnt >= pl_per - 1'b1) ? '0 : pl_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  logic h_proc, h_fin, v_fin;
  assign h_proc = (!v_shaped && cs.insertion_inhibit) ? 1'b1
                : (cs.input_source_select ? h_neg : sep_h);
  assign h_fin = (cs.output_source_select && cs.line_detect_flag)
               ? h_proc : (pl_cnt >= PSEUDO_LOW);
  assign v_fin = (cs.output_source_select && cs.frame_detect_flag)
               ? v_shaped : (pf_cnt >= PSEUDO_LOW);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_sync_out  <= 1'b1;
      frame_sync_out <= 1'b1;
    end else begin
      line_sync_out  <= h_fin;
      frame_sync_out <= v_fin;
    end
  end

  // ----------------------------------------------------------------
  // line and frame clock counters
  // ----------------------------------------------------------------
  logic [6:0]  div16;
  logic [11:0] line_cnt, line_hold;
  logic [12:0] frame_cnt, frame_hold;
  logic        line_over, line_over_hold, v_lead;
  assign v_lead = vs_prev && !v_src;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div16          <= 7'h00;
      line_cnt       <= 12'h000;
      line_hold      <= 12'h000;
      line_over      <= 1'b0;
      line_over_hold <= 1'b0;
      frame_cnt      <= 13'h0000;
      frame_hold     <= 13'h0000;
    end else if (v_lead) begin
      line_hold      <= line_cnt;
      line_over_hold <= line_over;
      frame_hold     <= frame_cnt;
      line_cnt       <= 12'h000;
      line_over      <= 1'b0;
      frame_cnt      <= 13'h0000;
      div16          <= 7'h00;
    end else begin
      div16 <= (div16 == 7'(`BUS_TO_CLK(`FRAME_DIV) - 1)) ? 7'h00 : div16 + 7'h01;
      if (div16 == 7'h00 && !(&frame_cnt)) frame_cnt <= frame_cnt + 13'h0001;
      if (!hp_neg && h_src) begin
        if (&line_cnt) line_over <= 1'b1;
        line_cnt <= line_cnt + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt latch
  // ----------------------------------------------------------------
  logic frame_irq_enable, irq_latch;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) irq_latch <= 1'b0;
    else if (v_lead && frame_irq_enable) irq_latch <= 1'b1;
    else if (vector_fetch) irq_latch <= 1'b0;
  end
  assign frame_irq = irq_latch && !cpu_irq_mask;

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  logic wr, rd_hit;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign rd_hit  = paddr == `ADDR_CONTROL_STATUS || paddr == `ADDR_LINE_COUNT
                || paddr == `ADDR_FRAME_COUNT || paddr == `ADDR_IRQ_CONTROL;
  assign pslverr = psel && penable && !rd_hit;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_source_select <= 1'b0;
      insertion_inhibit    <= 1'b0;
      pseudo_rate_select   <= 1'b0;
      input_source_select  <= 1'b0;
      frame_irq_enable     <= 1'b0;
    end else begin
      if (wr && paddr == `ADDR_CONTROL_STATUS) begin
        output_source_select <= pwdata[`BIT_OUT_SEL]
                              && cs.frame_detect_flag && cs.line_detect_flag;
        insertion_inhibit    <= pwdata[`BIT_INS_INHIBIT];
        pseudo_rate_select   <= pwdata[`BIT_RATE_SEL];
        input_source_select  <= pwdata[`BIT_SRC_SEL];
      end
      if (!cs.frame_detect_flag || !cs.line_detect_flag)
        output_source_select <= 1'b0;
      if (wr && paddr == `ADDR_IRQ_CONTROL) frame_irq_enable <= pwdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `ADDR_CONTROL_STATUS: prdata <= {24'h000000, cs};
        `ADDR_LINE_COUNT:     prdata <= {16'h0000, line_over_hold, 3'h0, line_hold};
        `ADDR_FRAME_COUNT:    prdata <= {19'h00000, frame_hold};
        `ADDR_IRQ_CONTROL:    prdata <= {24'h000000, irq_latch, 6'h00, frame_irq_enable};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== design/sync_processor_cfg.svh
// offsets, field positions, reset values and timing counts of the sync processor
`ifndef SYNC_PROCESSOR_CFG_SVH
`define SYNC_PROCESSOR_CFG_SVH
`define ADDR_CONTROL_STATUS  12'h00c
`define ADDR_LINE_COUNT      12'h010
`define ADDR_FRAME_COUNT     12'h014
`define ADDR_IRQ_CONTROL     12'h018
`define CS_RESET             8'h00
`define BIT_FRAME_POL        7
`define BIT_LINE_POL         6
`define BIT_FRAME_DET        5
`define BIT_LINE_DET         4
`define BIT_OUT_SEL          3
`define BIT_INS_INHIBIT      2
`define BIT_RATE_SEL         1
`define BIT_SRC_SEL          0
`define BUS_NS               500
`define CLK_NS               100
// a time in bus cycles becomes system clock cycles
`define BUS_TO_CLK(n)        ((n) * `BUS_NS / `CLK_NS)
`define FRAME_LOW_LIMIT      1024
`define LONG_PULSE           16
`define POL_COUNT            8
`define FRAME_WIDTH_MAX      960
`define FRAME_PERIOD_MAX     131000
`define LINE_WIDTH_MAX       16
`define LINE_PERIOD_MIN      18
`define LINE_PERIOD_MAX      256
`define PSEUDO_FRAME         31488
`define PSEUDO_LINE_SLOW     41
`define PSEUDO_LINE_FAST     32
`define WIDEN_NS             9500
`define WIDEN_CYCLES         ((`WIDEN_NS + `CLK_NS - 1) / `CLK_NS)
`define FRAME_DIV            16
`endif

// ===== design/sync_processor_pkg.sv
// types shared by the sync processor
package sync_processor_pkg;
  typedef struct packed {
    logic frame_polarity_flag;
    logic line_polarity_flag;
    logic frame_detect_flag;
    logic line_detect_flag;
    logic output_source_select;
    logic insertion_inhibit;
    logic pseudo_rate_select;
    logic input_source_select;
  } control_status_t;
  typedef struct packed {
    logic line;
    logic frame;
  } sync_pair_t;
  typedef enum logic [1:0] {SEP_PASS, SEP_ARMED, SEP_VERT} sep_state_t;
endpackage

// ===== dv/sync_source.sv
// incoming video sync source model driving the raw sync inputs
`timescale 1ns/10ps
`default_nettype none
module sync_source (
  input  wire logic        clk_sys,
  input  wire logic        line_on,
  input  wire logic        frame_on,
  input  wire logic        line_pos,
  input  wire logic        frame_pos,
  input  wire logic [15:0] line_per,
  input  wire logic [15:0] frame_per,
  output logic             line_sync,
  output logic             frame_sync
);
  localparam logic [15:0] LINE_WID  = 16'h000a;
  localparam logic [15:0] FRAME_WID = 16'h0032;
  logic [15:0] lc = 16'h0000;
  logic [15:0] fc = 16'h0000;
  always_ff @(posedge clk_sys) begin
    lc <= (!line_on || lc >= line_per - 16'h0001) ? 16'h0000 : lc + 16'h0001;
    fc <= (!frame_on || fc >= frame_per - 16'h0001) ? 16'h0000 : fc + 16'h0001;
  end
  // an absent source idles high; the active level follows the chosen polarity
  assign line_sync  = line_on ? ((lc < LINE_WID) ~^ line_pos) : 1'b1;
  assign frame_sync = frame_on ? ((fc < FRAME_WID) ~^ frame_pos) : 1'b1;
endmodule
`default_nettype wire

// ===== dv/sync_processor_props.sv
// port checker for the sync processor
`timescale 1ns/10ps
`default_nettype none
`include "sync_processor_cfg.svh"
module sync_processor_props #(
  parameter int unsigned FRAME_PERIOD_CYCLES = 1,
  parameter int unsigned PSEUDO_FRAME_CYCLES = 1
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_irq_mask,
  input wire logic        vector_fetch,
  input wire logic        frame_irq,
  input wire logic        line_sync_out,
  input wire logic        frame_sync_out
);
  logic acc;
  logic mapped;
  logic irq_en;
  assign acc = psel && penable;
  assign mapped = paddr == `ADDR_CONTROL_STATUS || paddr == `ADDR_LINE_COUNT ||
                  paddr == `ADDR_FRAME_COUNT || paddr == `ADDR_IRQ_CONTROL;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_en <= 1'b0;
    end else if (acc && pwrite && paddr == `ADDR_IRQ_CONTROL) begin
      irq_en <= pwdata[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ready_access_a: assert property (acc |-> pready) else $error("access without ready");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error flag");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("spurious error flag");
  unmapped_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  irq_mask_a: assert property (cpu_irq_mask |-> !frame_irq)
    else $error("interrupt while masked");
  irq_clear_a: assert property (vector_fetch |=> !frame_irq)
    else $error("latch not cleared by fetch");
  irq_enable_a: assert property ($rose(frame_irq) && $stable(cpu_irq_mask) |-> irq_en)
    else $error("interrupt while disabled");
  irq_readback_a: assert property
    (acc && !pwrite && paddr == `ADDR_IRQ_CONTROL |-> prdata[0] == irq_en)
    else $error("enable bit readback wrong");
  reset_quiet_a: assert property ($rose(resetn) |-> line_sync_out && frame_sync_out && !frame_irq)
    else $error("outputs active in reset");
  cover property ($rose(frame_irq));
  cover property (acc && pslverr);
  cover property (vector_fetch && frame_irq);
endmodule
bind sync_processor sync_processor_props #(
  .FRAME_PERIOD_CYCLES(FRAME_PERIOD_CYCLES),
  .PSEUDO_FRAME_CYCLES(PSEUDO_FRAME_CYCLES)
) u_sync_processor_props (.*);
`default_nettype wire

// ===== dv/tb.sv
// self-checking testbench for the sync processor
`timescale 1ns/10ps
`default_nettype none
`include "sync_processor_cfg.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, frame_irq, line_sync_out, frame_sync_out, err;
  logic        cpu_irq_mask = 1'b0;
  logic        vector_fetch = 1'b0;
  logic        line_sync_in, frame_sync_in;
  logic        line_on = 1'b0;
  logic        frame_on = 1'b0;
  logic        line_pos = 1'b0;
  logic        frame_pos = 1'b0;
  logic [15:0] frame_per = 16'h05dc;
  int          err_total = 0;
  int          n_checks = 0;
  int          p;
  initial forever #50 clk_sys = ~clk_sys;
  sync_processor #(.FRAME_PERIOD_CYCLES(8000), .PSEUDO_FRAME_CYCLES(1000)) u_sync_processor (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in), .cpu_irq_mask(cpu_irq_mask),
    .vector_fetch(vector_fetch), .frame_irq(frame_irq), .line_sync_out(line_sync_out),
    .frame_sync_out(frame_sync_out));
  sync_source u_sync_source (.clk_sys(clk_sys), .line_on(line_on), .frame_on(frame_on),
    .line_pos(line_pos), .frame_pos(frame_pos), .line_per(16'h0064), .frame_per(frame_per),
    .line_sync(line_sync_in), .frame_sync(frame_sync_in));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles from a falling edge to the next fall (period) or rise (width)
  task automatic meas(input bit fr, input bit wid, output int q);
    logic prev, cur;
    int n;
    n = 0;
    q = 0;
    cur = 1'b0;
    do begin
      @(posedge clk_sys);
      prev = cur;
      cur = fr ? frame_sync_out : line_sync_out;
      n++;
    end while (!(prev === 1'b1 && cur === 1'b0) && n < 20000);
    do begin
      @(posedge clk_sys);
      prev = cur;
      cur = fr ? frame_sync_out : line_sync_out;
      q++;
    end while (!(wid ? cur === 1'b1 : (prev === 1'b1 && cur === 1'b0)) && q < 20000);
    if (n >= 20000 || q >= 20000) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic fetch();
    @(posedge clk_sys);
    vector_fetch <= 1'b1;
    @(posedge clk_sys);
    vector_fetch <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd, {24'h0, `CS_RESET});
    apb(12'h020, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic s_pseudo();
    meas(0, 0, p);
    chk(p, 205);
    meas(1, 0, p);
    chk(p, 1000);
    apb(`ADDR_CONTROL_STATUS, 1'b1, 32'h0a);
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h02);
    repeat (300) @(posedge clk_sys);
    meas(0, 0, p);
    chk(p, 160);
  endtask
  task automatic s_separate();
    @(posedge clk_sys);
    line_on <= 1'b1;
    frame_on <= 1'b1;
    apb(`ADDR_CONTROL_STATUS, 1'b1, 32'h01);
    repeat (5000) @(posedge clk_sys);
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h31);
    apb(`ADDR_CONTROL_STATUS, 1'b1, 32'h09);
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h39);
    meas(0, 0, p);
    chk(p, 100);
    meas(1, 1, p);
    chk(p, 50);
    apb(`ADDR_LINE_COUNT, 1'b0, 32'h0);
    chk(rd[11:0] >= 12'd14 && rd[11:0] <= 12'd16, 1);
    apb(`ADDR_FRAME_COUNT, 1'b0, 32'h0);
    chk(rd[12:0] >= 13'd18 && rd[12:0] <= 13'd19, 1);
  endtask
  task automatic s_irq();
    int n;
    n = 0;
    apb(`ADDR_IRQ_CONTROL, 1'b1, 32'h1);
    while (frame_irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(frame_irq, 1);
    fetch();
    chk(frame_irq, 0);
    apb(`ADDR_IRQ_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h01);
    cpu_irq_mask <= 1'b1;
    repeat (1600) @(posedge clk_sys);
    chk(frame_irq, 0);
    apb(`ADDR_IRQ_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h81);
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(frame_irq, 1);
    fetch();
  endtask
  task automatic s_drop();
    @(posedge clk_sys);
    line_on <= 1'b0;
    repeat (3000) @(posedge clk_sys);
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h21);
    meas(0, 0, p);
    chk(p, 205);
  endtask
  task automatic s_polarity();
    @(posedge clk_sys);
    line_on <= 1'b1;
    line_pos <= 1'b1;
    frame_pos <= 1'b1;
    frame_per <= 16'h1770;
    repeat (14000) @(posedge clk_sys);
    apb(`ADDR_CONTROL_STATUS, 1'b0, 32'h0);
    chk(rd & 32'hc0, 32'hc0);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s_reset();
    s_pseudo();
    s_separate();
    s_irq();
    s_drop();
    s_polarity();
    finish_test();
  end
endmodule
`default_nettype wire
